// >>> rtl/pin_mux_and_floppy_config.sv
// Pin-function selection and floppy controller configuration bank.
// Assumes an APB master on pclk and a pad ring that reads the pin roles.
// How it works
// RQ1 - Pin 75: fan speed input 3 or GPIO 57, ignored under 4-Mbit flash.
// RQ2 - Pins 74 and 73: fan speed inputs 2 and 1, or GPIO 56 and 55.
// RQ3 - Pins 48, 47, 34: flash write, select, read strobes, or GPIO 54-52.
// RQ4 - Pins 33 and 32: flash address 17 and 16, or GPIO 51 and 50.
// RQ5 - Set-5 selection register at index 29h resets to E0h.
// RQ6 - Pin 85: infrared or MIDI input by parallel control bit 6, or GPIO 67.
// RQ7 - Pin 84: infrared or MIDI output by the same bit, or GPIO 66.
// RQ8 - Pins 83 and 82: infrared receive and transmit, or GPIO 65 and 64.
// RQ9 - Pin 81: power management event output, or GPIO 63.
// RQ10 - Pins 80, 79, 78: fan drive outputs 3, 2, 1, or GPIO 62-60.
// RQ11 - Set-6 selection register at index 2Ah resets to FFh.
// RQ12 - Override register reads from any device, writes only with device 04h.
// RQ13 - Override bits 7, 6, 3 force fan drive outputs 2, 1, 3.
// RQ14 - Override bits 2, 1, 0 force fan speed inputs 3, 0, 1.
// RQ15 - Override register at 2Bh resets to zero; bits 5-4 reserved.
// RQ16 - Software must never set the two factory test registers.
// RQ17 - Floppy activate bit 0 enables the controller; resets disabled.
// RQ18 - Floppy base address from 60h and 61h; other address bits read zero.
// RQ19 - Floppy interrupt level in 70h bits 3-0, reset 06h.
// RQ20 - Floppy DMA channel in 74h bits 2-0, reset 02h.
// RQ21 - Special bit 3 shares the interrupt, bit 2 swaps drives A and B.
// RQ22 - Special bit 1 selects three-mode, bit 0 protects against writes.
// RQ23 - Set-4 selection register at 28h resets to FFh.
// RQ24 - Index 24h bit 3 makes pin 75 flash address line 18.
// RQ25 - New pin selection takes effect at the edge completing the write.
`timescale 1ns/1ns
`default_nettype none

module pin_mux_and_floppy_config (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pin_mux_pkg::ADDR_W-1:0] paddr,
	input wire logic [pin_mux_pkg::DATA_W-1:0] pwdata,
	output logic [pin_mux_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pin roles for the pad ring.
	output pin_mux_pkg::pin_mux_t pin_mux,
	// Floppy controller configuration.
	output pin_mux_pkg::floppy_cfg_t floppy_cfg
);

	logic [7:0] logical_device_number_q, logical_device_number_d;
	logic [7:0] flash_cfg_q, flash_cfg_d;
	logic [7:0] parallel_control_two_q, parallel_control_two_d;
	logic [7:0] pin_select_set4_q, pin_select_set4_d;
	logic [7:0] pin_select_set5_q, pin_select_set5_d;
	logic [7:0] pin_select_set6_q, pin_select_set6_d;
	logic [7:0] fan_override_set4_q, fan_override_set4_d;
	logic [7:0] factory_test_one_q, factory_test_one_d;
	logic [7:0] factory_test_two_q, factory_test_two_d;
	logic [7:0] floppy_activate_q, floppy_activate_d;
	logic [7:0] floppy_base_high_q, floppy_base_high_d;
	logic [7:0] floppy_base_low_q, floppy_base_low_d;
	logic [7:0] floppy_irq_level_q, floppy_irq_level_d;
	logic [7:0] floppy_dma_channel_q, floppy_dma_channel_d;
	logic [7:0] floppy_special_one_q, floppy_special_one_d;
	logic [pin_mux_pkg::DATA_W-1:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	pin_mux_pkg::pin_mux_t pin_mux_q, pin_mux_d;
	logic setup;
	logic wr_done;
	logic addr_bad;
	logic [7:0] idx;
	logic [7:0] wdata;
	logic floppy_sel;
	logic fan_sel;

	// Picks a pin role; forced alternate wins over the GPIO bit.
	function automatic pin_mux_pkg::pin_fn_t pick_role(input logic gpio,
			input logic force_alt, input logic secondary);
		if (force_alt) begin
			pick_role = pin_mux_pkg::PIN_ALT;
		end else if (gpio) begin
			pick_role = pin_mux_pkg::PIN_GPIO;
		end else if (secondary) begin
			pick_role = pin_mux_pkg::PIN_ALT;
		end else begin
			pick_role = pin_mux_pkg::PIN_PRIMARY;
		end
	endfunction

	// Is the index one of the mapped registers.
	function automatic logic is_mapped(input logic [7:0] i);
		case (i)
			pin_mux_pkg::IDX_DEV_NUM, pin_mux_pkg::IDX_FLASH_CFG,
			pin_mux_pkg::IDX_SET4, pin_mux_pkg::IDX_SET5,
			pin_mux_pkg::IDX_SET6, pin_mux_pkg::IDX_OVR4,
			pin_mux_pkg::IDX_PAR_CTL2, pin_mux_pkg::IDX_TEST1,
			pin_mux_pkg::IDX_TEST2, pin_mux_pkg::IDX_FD_ACT,
			pin_mux_pkg::IDX_FD_BASE_HI, pin_mux_pkg::IDX_FD_BASE_LO,
			pin_mux_pkg::IDX_FD_IRQ, pin_mux_pkg::IDX_FD_DMA,
			pin_mux_pkg::IDX_FD_SPEC1: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	// Next value of a register: masked write data when selected.
	function automatic logic [7:0] next_reg(input logic [7:0] cur,
			input logic hit, input logic [7:0] d, input logic [7:0] mask);
		next_reg = hit ? (d & mask) : cur;
	endfunction

	assign setup = psel & ~penable;
	assign idx = paddr[9:2];
	assign wdata = pwdata[7:0];
	// Misaligned, out-of-range and unmapped accesses are refused with an
	// error, and a refused write leaves every register as it was.
	assign addr_bad = (paddr[1:0] != 2'h0) || (paddr[11:10] != 2'h0) ||
		!is_mapped(idx);
	// A write lands only at the edge that ends the access phase.
	assign wr_done = psel & penable & pready_q & pwrite & ~pslverr_q;
	// Device-banked floppy registers answer only while device 00h is chosen.
	assign floppy_sel = (logical_device_number_q == pin_mux_pkg::DEV_FLOPPY);
	// Only the fan device may write the override register.
	assign fan_sel = (logical_device_number_q == pin_mux_pkg::DEV_FAN);

	// Reserved bits are masked off at the write, so they always read zero.
	always_comb begin
		logical_device_number_d = next_reg(logical_device_number_q,
			wr_done && idx == pin_mux_pkg::IDX_DEV_NUM, wdata,
			pin_mux_pkg::MASK_ALL);
		flash_cfg_d = next_reg(flash_cfg_q,
			wr_done && idx == pin_mux_pkg::IDX_FLASH_CFG, wdata,
			pin_mux_pkg::MASK_ALL);
		parallel_control_two_d = next_reg(parallel_control_two_q,
			wr_done && idx == pin_mux_pkg::IDX_PAR_CTL2, wdata,
			pin_mux_pkg::MASK_ALL);
		pin_select_set4_d = next_reg(pin_select_set4_q,
			wr_done && idx == pin_mux_pkg::IDX_SET4, wdata,
			pin_mux_pkg::MASK_ALL);
		pin_select_set5_d = next_reg(pin_select_set5_q,
			wr_done && idx == pin_mux_pkg::IDX_SET5, wdata,
			pin_mux_pkg::MASK_ALL);
		pin_select_set6_d = next_reg(pin_select_set6_q,
			wr_done && idx == pin_mux_pkg::IDX_SET6, wdata,
			pin_mux_pkg::MASK_ALL);
		// RQ12 device-gated write
		// RQ15 reserved bits held
		fan_override_set4_d = next_reg(fan_override_set4_q,
			wr_done && fan_sel && idx == pin_mux_pkg::IDX_OVR4, wdata,
			pin_mux_pkg::MASK_OVR4);
		// RQ16 storage only
		factory_test_one_d = next_reg(factory_test_one_q,
			wr_done && idx == pin_mux_pkg::IDX_TEST1, wdata,
			pin_mux_pkg::MASK_ALL);
		factory_test_two_d = next_reg(factory_test_two_q,
			wr_done && idx == pin_mux_pkg::IDX_TEST2, wdata,
			pin_mux_pkg::MASK_ALL);
		// RQ17 enable bit only
		floppy_activate_d = next_reg(floppy_activate_q,
			wr_done && floppy_sel && idx == pin_mux_pkg::IDX_FD_ACT,
			wdata, pin_mux_pkg::MASK_FD_ACT);
		// RQ18 address bit masks
		floppy_base_high_d = next_reg(floppy_base_high_q,
			wr_done && floppy_sel && idx == pin_mux_pkg::IDX_FD_BASE_HI,
			wdata, pin_mux_pkg::MASK_FD_BASE_HI);
		floppy_base_low_d = next_reg(floppy_base_low_q,
			wr_done && floppy_sel && idx == pin_mux_pkg::IDX_FD_BASE_LO,
			wdata, pin_mux_pkg::MASK_FD_BASE_LO);
		// RQ19 level field
		floppy_irq_level_d = next_reg(floppy_irq_level_q,
			wr_done && floppy_sel && idx == pin_mux_pkg::IDX_FD_IRQ,
			wdata, pin_mux_pkg::MASK_FD_IRQ);
		// RQ20 channel field
		floppy_dma_channel_d = next_reg(floppy_dma_channel_q,
			wr_done && floppy_sel && idx == pin_mux_pkg::IDX_FD_DMA,
			wdata, pin_mux_pkg::MASK_FD_DMA);
		// RQ22 upper bits reserved
		floppy_special_one_d = next_reg(floppy_special_one_q,
			wr_done && floppy_sel && idx == pin_mux_pkg::IDX_FD_SPEC1,
			wdata, pin_mux_pkg::MASK_FD_SPEC1);
	end

	// RQ25 roles from next values
	always_comb begin
		pin_mux_d = pin_mux_pkg::PIN_MUX_RST;
		// RQ1 pin 75 role
		// RQ24 flash address 18
		pin_mux_d.pin75 = pick_role(pin_select_set5_d[7],
			flash_cfg_d[pin_mux_pkg::FLASH_4M_BIT], 1'b0);
		// RQ2 fan speed pins
		pin_mux_d.fan_speed_gpio = pin_select_set5_d[6:5];
		// RQ3 flash strobe pins
		// RQ4 flash address pins
		pin_mux_d.flash_gpio = pin_select_set5_d[4:0];
		// RQ6 infrared or MIDI input
		pin_mux_d.pin85 = pick_role(pin_select_set6_d[7], 1'b0,
			parallel_control_two_d[pin_mux_pkg::MIDI_SEL_BIT]);
		// RQ7 infrared or MIDI output
		pin_mux_d.pin84 = pick_role(pin_select_set6_d[6], 1'b0,
			parallel_control_two_d[pin_mux_pkg::MIDI_SEL_BIT]);
		// RQ8 infrared pins
		// RQ9 power event pin
		// RQ10 fan drive pins
		pin_mux_d.set6_gpio = pin_select_set6_d[5:0];
		// RQ13 fan drive override
		// RQ14 fan speed override
		for (int p = 0; p < 6; p++) begin
			pin_mux_d.set4_pin[p] = pick_role(
				pin_select_set4_d[pin_mux_pkg::OVR_BIT_POS[p]],
				fan_override_set4_d[pin_mux_pkg::OVR_BIT_POS[p]], 1'b0);
		end
	end

	// Register storage. Test registers are kept as plain storage and drive
	// nothing, so a stray write to them cannot disturb the pins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			logical_device_number_q <= pin_mux_pkg::RST_ZERO;
			flash_cfg_q <= pin_mux_pkg::RST_ZERO;
			parallel_control_two_q <= pin_mux_pkg::RST_ZERO;
			// RQ23 set-4 reset
			pin_select_set4_q <= pin_mux_pkg::RST_SET4;
			// RQ5 set-5 reset
			pin_select_set5_q <= pin_mux_pkg::RST_SET5;
			// RQ11 set-6 reset
			pin_select_set6_q <= pin_mux_pkg::RST_SET6;
			fan_override_set4_q <= pin_mux_pkg::RST_ZERO;
			factory_test_one_q <= pin_mux_pkg::RST_ZERO;
			factory_test_two_q <= pin_mux_pkg::RST_ZERO;
			floppy_activate_q <= pin_mux_pkg::RST_ZERO;
			floppy_base_high_q <= pin_mux_pkg::RST_FD_BASE_HI;
			floppy_base_low_q <= pin_mux_pkg::RST_FD_BASE_LO;
			floppy_irq_level_q <= pin_mux_pkg::RST_FD_IRQ;
			floppy_dma_channel_q <= pin_mux_pkg::RST_FD_DMA;
			floppy_special_one_q <= pin_mux_pkg::RST_ZERO;
		end else begin
			logical_device_number_q <= logical_device_number_d;
			flash_cfg_q <= flash_cfg_d;
			parallel_control_two_q <= parallel_control_two_d;
			pin_select_set4_q <= pin_select_set4_d;
			pin_select_set5_q <= pin_select_set5_d;
			pin_select_set6_q <= pin_select_set6_d;
			fan_override_set4_q <= fan_override_set4_d;
			factory_test_one_q <= factory_test_one_d;
			factory_test_two_q <= factory_test_two_d;
			floppy_activate_q <= floppy_activate_d;
			floppy_base_high_q <= floppy_base_high_d;
			floppy_base_low_q <= floppy_base_low_d;
			floppy_irq_level_q <= floppy_irq_level_d;
			floppy_dma_channel_q <= floppy_dma_channel_d;
			floppy_special_one_q <= floppy_special_one_d;
		end
	end

	// Pin roles are registered so the pads see flip-flop outputs.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_mux_q <= pin_mux_pkg::PIN_MUX_RST;
		end else begin
			pin_mux_q <= pin_mux_d;
		end
	end

	// APB answer: read data and error are caught in the setup cycle, and
	// pready rises for the first access cycle, so no access has a wait state.
	// A refused access still gets its single answer, with the error flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= setup;
			if (setup) begin
				pslverr_q <= addr_bad;
				prdata_q <= '0;
				if (!addr_bad && !pwrite) begin
					case (idx)
						pin_mux_pkg::IDX_DEV_NUM:
							prdata_q[7:0] <= logical_device_number_q;
						pin_mux_pkg::IDX_FLASH_CFG:
							prdata_q[7:0] <= flash_cfg_q;
						pin_mux_pkg::IDX_PAR_CTL2:
							prdata_q[7:0] <= parallel_control_two_q;
						pin_mux_pkg::IDX_SET4:
							prdata_q[7:0] <= pin_select_set4_q;
						pin_mux_pkg::IDX_SET5:
							prdata_q[7:0] <= pin_select_set5_q;
						pin_mux_pkg::IDX_SET6:
							prdata_q[7:0] <= pin_select_set6_q;
						// RQ12 read from any device
						pin_mux_pkg::IDX_OVR4:
							prdata_q[7:0] <= fan_override_set4_q;
						pin_mux_pkg::IDX_TEST1:
							prdata_q[7:0] <= factory_test_one_q;
						pin_mux_pkg::IDX_TEST2:
							prdata_q[7:0] <= factory_test_two_q;
						pin_mux_pkg::IDX_FD_ACT:
							prdata_q[7:0] <= floppy_sel ? floppy_activate_q : 8'h00;
						pin_mux_pkg::IDX_FD_BASE_HI:
							prdata_q[7:0] <= floppy_sel ? floppy_base_high_q : 8'h00;
						pin_mux_pkg::IDX_FD_BASE_LO:
							prdata_q[7:0] <= floppy_sel ? floppy_base_low_q : 8'h00;
						pin_mux_pkg::IDX_FD_IRQ:
							prdata_q[7:0] <= floppy_sel ? floppy_irq_level_q : 8'h00;
						pin_mux_pkg::IDX_FD_DMA:
							prdata_q[7:0] <= floppy_sel ? floppy_dma_channel_q : 8'h00;
						pin_mux_pkg::IDX_FD_SPEC1:
							prdata_q[7:0] <= floppy_sel ? floppy_special_one_q : 8'h00;
						default:
							prdata_q[7:0] <= 8'h00;
					endcase
				end
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign pin_mux = pin_mux_q;

	// The floppy settings are plain slices of the stored registers, so the
	// controller sees a new value from the edge at which the write lands.
	// RQ17 controller enable
	assign floppy_cfg.enable = floppy_activate_q[0];
	// RQ18 base address assembly
	assign floppy_cfg.base_addr = {4'h0, floppy_base_high_q[3:0],
		floppy_base_low_q[7:3], 3'h0};
	// RQ19 interrupt level
	assign floppy_cfg.irq_level = floppy_irq_level_q[3:0];
	// RQ20 DMA channel
	assign floppy_cfg.dma_channel = floppy_dma_channel_q[2:0];
	// RQ21 share and swap
	assign floppy_cfg.irq_share = floppy_special_one_q[3];
	assign floppy_cfg.swap_ab = floppy_special_one_q[2];
	// RQ22 mode and protect
	assign floppy_cfg.three_mode = floppy_special_one_q[1];
	assign floppy_cfg.write_protect = floppy_special_one_q[0];

endmodule // pin_mux_and_floppy_config

`default_nettype wire

// >>> rtl/pin_mux_pkg.sv
// Constants and carrier types for the pin-select and floppy config bank.
// Assumes an APB master on pclk; register index times four is the address.
package pin_mux_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// Register indices; byte address is four times the index.
	localparam logic [7:0] IDX_DEV_NUM = 8'h07;
	localparam logic [7:0] IDX_FLASH_CFG = 8'h24;
	localparam logic [7:0] IDX_SET4 = 8'h28;
	localparam logic [7:0] IDX_SET5 = 8'h29;
	localparam logic [7:0] IDX_SET6 = 8'h2A;
	localparam logic [7:0] IDX_OVR4 = 8'h2B;
	localparam logic [7:0] IDX_PAR_CTL2 = 8'h2C;
	localparam logic [7:0] IDX_TEST1 = 8'h2E;
	localparam logic [7:0] IDX_TEST2 = 8'h2F;
	localparam logic [7:0] IDX_FD_ACT = 8'h30;
	localparam logic [7:0] IDX_FD_BASE_HI = 8'h60;
	localparam logic [7:0] IDX_FD_BASE_LO = 8'h61;
	localparam logic [7:0] IDX_FD_IRQ = 8'h70;
	localparam logic [7:0] IDX_FD_DMA = 8'h74;
	localparam logic [7:0] IDX_FD_SPEC1 = 8'hF0;

	// Logical device numbers that gate writes.
	localparam logic [7:0] DEV_FLOPPY = 8'h00;
	localparam logic [7:0] DEV_FAN = 8'h04;

	// Reset values.
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_SET4 = 8'hFF;
	localparam logic [7:0] RST_SET5 = 8'hE0;
	localparam logic [7:0] RST_SET6 = 8'hFF;
	localparam logic [7:0] RST_FD_BASE_HI = 8'h03;
	localparam logic [7:0] RST_FD_BASE_LO = 8'hF0;
	localparam logic [7:0] RST_FD_IRQ = 8'h06;
	localparam logic [7:0] RST_FD_DMA = 8'h02;

	// Writable bit masks; other bits hold zero and read as zero.
	localparam logic [7:0] MASK_ALL = 8'hFF;
	localparam logic [7:0] MASK_OVR4 = 8'hCF;
	localparam logic [7:0] MASK_FD_ACT = 8'h01;
	localparam logic [7:0] MASK_FD_BASE_HI = 8'h0F;
	localparam logic [7:0] MASK_FD_BASE_LO = 8'hF8;
	localparam logic [7:0] MASK_FD_IRQ = 8'h0F;
	localparam logic [7:0] MASK_FD_DMA = 8'h07;
	localparam logic [7:0] MASK_FD_SPEC1 = 8'h0F;

	// Field positions.
	localparam int unsigned FLASH_4M_BIT = 3;
	localparam int unsigned MIDI_SEL_BIT = 6;
	// Override bit for each set-4 pin: 56, 55, 52, 51, 50, 49.
	localparam logic [5:0][2:0] OVR_BIT_POS = {3'h7, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0};

	// Pin role: primary function, general purpose I/O, or the alternate.
	typedef enum logic [1:0] {
		PIN_PRIMARY,
		PIN_GPIO,
		PIN_ALT
	} pin_fn_t;

	// Pin roles driven to the pad ring; a set gpio bit means GPIO mode.
	typedef struct packed {
		pin_fn_t pin75;
		logic [1:0] fan_speed_gpio;
		logic [4:0] flash_gpio;
		pin_fn_t pin85;
		pin_fn_t pin84;
		logic [5:0] set6_gpio;
		pin_fn_t [5:0] set4_pin;
	} pin_mux_t;

	typedef struct packed {
		logic enable;
		logic [15:0] base_addr;
		logic [3:0] irq_level;
		logic [2:0] dma_channel;
		logic irq_share;
		logic swap_ab;
		logic three_mode;
		logic write_protect;
	} floppy_cfg_t;

	localparam pin_mux_t PIN_MUX_RST = '{
		pin75: PIN_GPIO,
		fan_speed_gpio: 2'h3,
		flash_gpio: 5'h00,
		pin85: PIN_GPIO,
		pin84: PIN_GPIO,
		set6_gpio: 6'h3F,
		set4_pin: {6{PIN_GPIO}}
	};

endpackage

// >>> test/pin_mux_and_floppy_config_tb.sv
// Self-checking bench for the pin-select and floppy config bank.
// Assumes the checker is bound in; this module masters APB itself.
`timescale 1ns/1ns
`default_nettype none
module pin_mux_and_floppy_config_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	pin_mux_pkg::pin_mux_t pin_mux;
	pin_mux_pkg::floppy_cfg_t floppy_cfg;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic err;
	logic [7:0] rs_i [12] = '{8'h29, 8'h2A, 8'h2B, 8'h2E, 8'h2F, 8'h30,
		8'h60, 8'h61, 8'h70, 8'h74, 8'hF0, 8'h28};
	logic [7:0] rs_v [12] = '{8'hE0, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h03, 8'hF0, 8'h06, 8'h02, 8'h00, 8'hFF};
	logic [7:0] fd_i [6] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hF0};
	logic [7:0] fd_m [6] = '{8'h01, 8'h0F, 8'hF8, 8'h0F, 8'h07, 8'h0F};

	always #25 pclk = ~pclk;

	pin_mux_and_floppy_config dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_mux(pin_mux),
		.floppy_cfg(floppy_cfg)
	);

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic cmp_w(input string n, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Setup, then access until pready; pready, read data and error are taken at that posedge, then it waits for the negedge.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		cmp_w("pready", 1'b1, pready);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, {2'b00, i, 2'b00}, d);
	endtask

	task automatic rdc(input logic [7:0] i, input logic [7:0] e);
		apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
		cmp_w($sformatf("reg %h", i), {24'h00_0000, e}, rd);
	endtask

	task automatic t_reset();
		for (int k = 0; k < 12; k++) begin
			rdc(rs_i[k], rs_v[k]);
		end
		cmp_w("pin_mux", pin_mux_pkg::PIN_MUX_RST, pin_mux);
		cmp_w("floppy", {4'h0, 1'b0, 16'h03F0, 4'h6, 3'h2, 4'h0},
			{4'h0, floppy_cfg});
	endtask

	task automatic s5(input logic [7:0] d, input pin_mux_pkg::pin_fn_t r);
		wr(pin_mux_pkg::IDX_SET5, d);
		cmp_w("pin75", r, pin_mux.pin75);
		cmp_w("set5", d[6:0], {pin_mux.fan_speed_gpio, pin_mux.flash_gpio});
	endtask

	task automatic s6(input logic [7:0] d, input pin_mux_pkg::pin_fn_t a,
		input pin_mux_pkg::pin_fn_t b);
		wr(pin_mux_pkg::IDX_SET6, d);
		cmp_w("pin85", a, pin_mux.pin85);
		cmp_w("pin84", b, pin_mux.pin84);
		cmp_w("set6", d[5:0], pin_mux.set6_gpio);
	endtask

	task automatic t_pins();
		s5(8'h00, pin_mux_pkg::PIN_PRIMARY);
		s5(8'h9A, pin_mux_pkg::PIN_GPIO);
		s5(8'h65, pin_mux_pkg::PIN_PRIMARY);
		wr(pin_mux_pkg::IDX_FLASH_CFG, 8'h08);
		s5(8'h80, pin_mux_pkg::PIN_ALT);
		s5(8'hE0, pin_mux_pkg::PIN_ALT);
		wr(pin_mux_pkg::IDX_FLASH_CFG, 8'h00);
		cmp_w("pin75", pin_mux_pkg::PIN_GPIO, pin_mux.pin75);
		s6(8'h00, pin_mux_pkg::PIN_PRIMARY, pin_mux_pkg::PIN_PRIMARY);
		wr(pin_mux_pkg::IDX_PAR_CTL2, 8'h40);
		s6(8'h15, pin_mux_pkg::PIN_ALT, pin_mux_pkg::PIN_ALT);
		s6(8'h80, pin_mux_pkg::PIN_GPIO, pin_mux_pkg::PIN_ALT);
		s6(8'h6A, pin_mux_pkg::PIN_ALT, pin_mux_pkg::PIN_GPIO);
		wr(pin_mux_pkg::IDX_PAR_CTL2, 8'h00);
		s6(8'hFF, pin_mux_pkg::PIN_GPIO, pin_mux_pkg::PIN_GPIO);
	endtask

	task automatic t_ovr();
		pin_mux_pkg::pin_fn_t e;
		logic [7:0] s4;
		s4 = 8'h0F;
		wr(pin_mux_pkg::IDX_SET4, s4);
		wr(pin_mux_pkg::IDX_OVR4, 8'hFF);
		rdc(pin_mux_pkg::IDX_OVR4, 8'h00);
		wr(pin_mux_pkg::IDX_DEV_NUM, pin_mux_pkg::DEV_FAN);
		for (int k = 0; k < 6; k++) begin
			wr(pin_mux_pkg::IDX_OVR4, 8'h01 << pin_mux_pkg::OVR_BIT_POS[k]);
			for (int j = 0; j < 6; j++) begin
				e = s4[pin_mux_pkg::OVR_BIT_POS[j]] ? pin_mux_pkg::PIN_GPIO :
					pin_mux_pkg::PIN_PRIMARY;
				if (j == k) e = pin_mux_pkg::PIN_ALT;
				cmp_w("set4 pin", e, pin_mux.set4_pin[j]);
			end
		end
		wr(pin_mux_pkg::IDX_OVR4, 8'hFF);
		wr(pin_mux_pkg::IDX_DEV_NUM, 8'h01);
		wr(pin_mux_pkg::IDX_OVR4, 8'h00);
		rdc(pin_mux_pkg::IDX_OVR4, 8'hCF);
		wr(pin_mux_pkg::IDX_DEV_NUM, pin_mux_pkg::DEV_FLOPPY);
	endtask

	task automatic t_fdc();
		for (int k = 0; k < 6; k++) begin
			wr(fd_i[k], 8'hFF);
			rdc(fd_i[k], fd_m[k]);
		end
		cmp_w("floppy", {4'h0, 1'b1, 16'h0FF8, 4'hF, 3'h7, 4'hF},
			{4'h0, floppy_cfg});
		wr(8'hF0, 8'h05);
		cmp_w("flags", 4'h5, floppy_cfg[3:0]);
		wr(pin_mux_pkg::IDX_DEV_NUM, 8'h01);
		rdc(8'h30, 8'h00);
		wr(8'h30, 8'h00);
		cmp_w("enable", 1'b1, floppy_cfg.enable);
		wr(pin_mux_pkg::IDX_DEV_NUM, 8'h00);
		wr(8'h30, 8'h00);
		cmp_w("enable", 1'b0, floppy_cfg.enable);
		apb(1'b1, 12'h4A4, 8'h00);
		cmp_w("slverr", 1'b1, err);
		rdc(pin_mux_pkg::IDX_SET5, 8'hE0);
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			wrap_up();
		end
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_pins();
		t_ovr();
		t_fdc();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		wrap_up();
	end
endmodule // pin_mux_and_floppy_config_tb
`default_nettype wire

// >>> test/pin_mux_checker.sv
// Assertion checker for the pin-select and floppy config bank.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module pin_mux_checker (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave side.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pin_mux_pkg::ADDR_W-1:0] paddr,
	input wire logic [pin_mux_pkg::DATA_W-1:0] pwdata,
	input wire logic [pin_mux_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Configuration outputs.
	input wire pin_mux_pkg::pin_mux_t pin_mux,
	input wire pin_mux_pkg::floppy_cfg_t floppy_cfg
);
	wire logic commit = psel && penable && pready && pwrite && !pslverr;
	wire logic [7:0] idx = paddr[9:2];
	logic [7:0] dev_num_q;
	logic flash_q;

	// Mirrors the selected logical device so write gating can be judged.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_num_q <= 8'h00;
		end else if (commit && idx == pin_mux_pkg::IDX_DEV_NUM) begin
			dev_num_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_q <= 1'b0;
		end else if (commit && idx == pin_mux_pkg::IDX_FLASH_CFG) begin
			flash_q <= pwdata[3];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence setup_s;
		psel && !penable;
	endsequence
	sequence wr_s(logic [7:0] i);
		commit && idx == i;
	endsequence

	pready_pulse_a: assert property (setup_s |=> pready ##1 !pready)
		else $error("pready did not pulse once after setup");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	set5_commit_a: assert property (wr_s(pin_mux_pkg::IDX_SET5) |=>
		{pin_mux.fan_speed_gpio, pin_mux.flash_gpio} == $past(pwdata[6:0]))
		else $error("set-5 pin roles missed the write");
	set6_commit_a: assert property (wr_s(pin_mux_pkg::IDX_SET6) |=>
		pin_mux.set6_gpio == $past(pwdata[5:0]))
		else $error("set-6 pin roles missed the write");
	flash_pin_a: assert property ((pin_mux.pin75 == pin_mux_pkg::PIN_ALT) == flash_q)
		else $error("pin 75 role disagrees with flash size");
	override_gate_a: assert property (wr_s(pin_mux_pkg::IDX_OVR4) ##0
		dev_num_q != pin_mux_pkg::DEV_FAN |=> $stable(pin_mux.set4_pin))
		else $error("override changed without fan device");
	base_zero_a: assert property (floppy_cfg.base_addr[15:12] == 4'h0 &&
		floppy_cfg.base_addr[2:0] == 3'h0)
		else $error("floppy base fixed bits not zero");
	dma_commit_a: assert property (wr_s(pin_mux_pkg::IDX_FD_DMA) ##0
		dev_num_q == pin_mux_pkg::DEV_FLOPPY |=>
		floppy_cfg.dma_channel == $past(pwdata[2:0]))
		else $error("floppy channel missed the write");
	cfg_hold_a: assert property (!(psel && penable && pwrite) |=> $stable(floppy_cfg))
		else $error("floppy config changed without a write");
endmodule // pin_mux_checker

bind pin_mux_and_floppy_config pin_mux_checker chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .pin_mux, .floppy_cfg
);
`default_nettype wire
